// ==== adc_result_pkg.sv ====
// Shared constants for the converter result and window detector block
package adc_result_pkg;
  localparam int          CODE_WIDTH        = 12;
  localparam int          WORD_WIDTH        = 16;
  localparam logic [7:0]  ADDR_RESULT_LOW   = 8'hBE;
  localparam logic [7:0]  ADDR_RESULT_HIGH  = 8'hBF;
  localparam logic [7:0]  ADDR_UPPER_LOW    = 8'hC4;
  localparam logic [7:0]  ADDR_UPPER_HIGH   = 8'hC5;
  localparam logic [7:0]  ADDR_LOWER_LOW    = 8'hC6;
  localparam logic [7:0]  ADDR_LOWER_HIGH   = 8'hC7;
  localparam logic [7:0]  ADDR_CONTROL      = 8'hE8;
  localparam int          BIT_LEFT_JUSTIFY  = 0;
  localparam int          BIT_WINDOW_MATCH  = 1;
  localparam int          BIT_IN_PROGRESS   = 4;
  localparam int          BIT_DONE          = 5;
  localparam logic [7:0]  RESET_RESULT      = 8'h00;
  localparam logic [7:0]  RESET_CONTROL     = 8'h00;
  localparam logic [15:0] RESET_UPPER_LIMIT = 16'hFFFF;
  localparam logic [15:0] RESET_LOWER_LIMIT = 16'h0000;
  localparam logic [7:0]  CONTROL_KEEP_MASK = 8'hCC;
endpackage

// ==== conv_result_if.sv ====
// Carrier between result formatter, window comparator and control logic
`timescale 1ns/1ps
`default_nettype none
interface conv_result_if;
  logic [11:0] code;
  logic        differential;
  logic        left_justify;
  logic [15:0] result_word;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic        window_hit;
  modport control (output code, differential, left_justify, upper_limit, lower_limit,
                   input result_word, window_hit);
  modport format (input code, differential, left_justify, output result_word);
  modport window (input result_word, differential, upper_limit, lower_limit,
                  output window_hit);
endinterface // conv_result_if
`default_nettype wire

// ==== result_formatter.sv ====
// Places a 12-bit code into the justified 16-bit result word
`timescale 1ns/1ps
`default_nettype none
module result_formatter
  import adc_result_pkg::*;
(
  conv_result_if.format link
);
  always_comb begin
    if (link.left_justify) begin
      link.result_word = {link.code, 4'h0};
    end else if (link.differential) begin
      link.result_word = {{4{link.code[11]}}, link.code};
    end else begin
      link.result_word = {4'h0, link.code};
    end
  end
endmodule // result_formatter
`default_nettype wire

// ==== window_compare.sv ====
// Compares the result word with the two limit words
`timescale 1ns/1ps
`default_nettype none
module window_compare
  import adc_result_pkg::*;
(
  conv_result_if.window link
);
  logic above_upper;
  logic below_lower;
  logic limits_swapped;

  always_comb begin
    if (link.differential) begin
      above_upper    = $signed(link.result_word) > $signed(link.upper_limit);
      below_lower    = $signed(link.result_word) < $signed(link.lower_limit);
      limits_swapped = $signed(link.lower_limit) > $signed(link.upper_limit);
    end else begin
      above_upper    = link.result_word > link.upper_limit;
      below_lower    = link.result_word < link.lower_limit;
      limits_swapped = link.lower_limit > link.upper_limit;
    end
    if (limits_swapped) begin
      link.window_hit = above_upper && below_lower;
    end else begin
      link.window_hit = above_upper || below_lower;
    end
  end
endmodule // window_compare
`default_nettype wire

// ==== adc_result_window_detect.sv ====
// Result registers, limit registers and window detection for the converter
// Operation
// - Right justified: high byte bits 3..0 are code top, 7..4 copy bit 3 when differential.
// - Left justified: high byte holds the eight most significant code bits.
// - Right justified: low byte holds the low eight code bits.
// - Left justified: low byte bits 7..4 hold low code nibble, 3..0 read zero.
// - Right justified upper nibble: sign for differential, zero for single-ended.
// - Right justified code scales with 2^12 single-ended, 2^11 differential.
// - Every result is compared with the limits in hardware, match is signalled.
// - Flag can mean inside or outside, chosen by the limit ordering.
// - Window match flag can be polled instead of used as interrupt.
// - Upper limit high byte is read/write at 0xC5, plus a low byte.
// - Lower limit high byte is read/write at 0xC7, plus a low byte.
// - Control bit 0 selects right (0) or left (1) justification.
// - Window match flag at control bit 1 stays set until software writes it.
// - Falling in-progress indication sets the done flag and may interrupt.
`timescale 1ns/1ps
`default_nettype none
module adc_result_window_detect
  import adc_result_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        conversion_in_progress,
  input  wire logic [11:0] conversion_code,
  input  wire logic        differential_input,
  output logic             start_request,
  output logic             conversion_done_flag,
  output logic             window_match_flag
);
  conv_result_if link ();

  // Write strobes, one per register
  logic        wr_result_low;
  logic        wr_result_high;
  logic        wr_upper_low;
  logic        wr_upper_high;
  logic        wr_lower_low;
  logic        wr_lower_high;
  logic        wr_control;
  logic        completion;
  logic [7:0]  control_view;

  // Register state and next values
  logic        busy_prev_reg,   busy_prev_next;
  logic [7:0]  result_low_reg,  result_low_next;
  logic [7:0]  result_high_reg, result_high_next;
  logic [15:0] upper_limit_reg, upper_limit_next;
  logic [15:0] lower_limit_reg, lower_limit_next;
  logic [7:0]  control_reg,     control_next;
  logic        start_reg,       start_next;
  logic        done_flag_reg,   done_flag_next;
  logic        match_flag_reg,  match_flag_next;
  logic [7:0]  rdata_reg,       rdata_next;

  // Live inputs and stored limits feed the formatter and the comparator
  assign link.code         = conversion_code;
  assign link.differential = differential_input;
  assign link.left_justify = control_reg[BIT_LEFT_JUSTIFY];
  assign link.upper_limit  = upper_limit_reg;
  assign link.lower_limit  = lower_limit_reg;

  // Formatting and window comparison are purely combinational
  result_formatter u_format (
    .link (link.format)
  );

  window_compare u_window (
    .link (link.window)
  );

  // Address decode for register writes
  always_comb begin
    wr_result_low  = 1'b0;
    wr_result_high = 1'b0;
    wr_upper_low   = 1'b0;
    wr_upper_high  = 1'b0;
    wr_lower_low   = 1'b0;
    wr_lower_high  = 1'b0;
    wr_control     = 1'b0;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_RESULT_LOW:  wr_result_low  = 1'b1;
        ADDR_RESULT_HIGH: wr_result_high = 1'b1;
        ADDR_UPPER_LOW:   wr_upper_low   = 1'b1;
        ADDR_UPPER_HIGH:  wr_upper_high  = 1'b1;
        ADDR_LOWER_LOW:   wr_lower_low   = 1'b1;
        ADDR_LOWER_HIGH:  wr_lower_high  = 1'b1;
        ADDR_CONTROL:     wr_control     = 1'b1;
        // Unmapped addresses raise no strobe
        default: ;
      endcase
    end
  end

  // Busy history; a high-to-low step marks the end of a conversion
  // The code must already be valid in the cycle busy is first seen low
  always_comb begin
    busy_prev_next = conversion_in_progress;
    completion     = busy_prev_reg && !conversion_in_progress;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_prev_reg <= 1'b0;
    end else begin
      busy_prev_reg <= busy_prev_next;
    end
  end

  // Low result byte; a software write in the completion cycle is lost
  always_comb begin
    result_low_next = result_low_reg;
    if (completion) begin
      result_low_next = link.result_word[7:0];
    end else if (wr_result_low) begin
      result_low_next = sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_low_reg <= RESET_RESULT;
    end else begin
      result_low_reg <= result_low_next;
    end
  end

  // High result byte, loaded in the same cycle as the low byte
  always_comb begin
    result_high_next = result_high_reg;
    if (completion) begin
      result_high_next = link.result_word[15:8];
    end else if (wr_result_high) begin
      result_high_next = sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_high_reg <= RESET_RESULT;
    end else begin
      result_high_reg <= result_high_next;
    end
  end

  // Greater-than limit word, one byte per write
  always_comb begin
    upper_limit_next = upper_limit_reg;
    // The comparator sees each byte as it lands; load limits while idle
    if (wr_upper_low) begin
      upper_limit_next[7:0] = sfr_wdata;
    end
    if (wr_upper_high) begin
      upper_limit_next[15:8] = sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      upper_limit_reg <= RESET_UPPER_LIMIT;
    end else begin
      upper_limit_reg <= upper_limit_next;
    end
  end

  // Less-than limit word, one byte per write
  always_comb begin
    lower_limit_next = lower_limit_reg;
    if (wr_lower_low) begin
      lower_limit_next[7:0] = sfr_wdata;
    end
    if (wr_lower_high) begin
      lower_limit_next[15:8] = sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lower_limit_reg <= RESET_LOWER_LIMIT;
    end else begin
      lower_limit_reg <= lower_limit_next;
    end
  end

  // Control storage; bits 1 and 5 are kept in their own flops, bit 4 reads the live busy level
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = sfr_wdata & (CONTROL_KEEP_MASK | 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      control_reg <= RESET_CONTROL;
    end else begin
      control_reg <= control_next;
    end
  end

  // One-cycle start pulse on a control write with the busy bit set
  // The converter itself sits outside; it only sees this pulse
  always_comb begin
    start_next = 1'b0;
    if (wr_control) begin
      start_next = sfr_wdata[BIT_IN_PROGRESS];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
    end
  end

  // Done flag; a hardware set wins over a software clear in the same cycle
  always_comb begin
    done_flag_next = done_flag_reg;
    if (wr_control) begin
      done_flag_next = sfr_wdata[BIT_DONE];
    end
    if (completion) begin
      done_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_flag_reg <= 1'b0;
    end else begin
      done_flag_reg <= done_flag_next;
    end
  end

  // Window match flag; sticky until software writes the bit, set wins
  // Only a finished conversion is judged; limit writes alone never set it
  always_comb begin
    match_flag_next = match_flag_reg;
    if (wr_control) begin
      match_flag_next = sfr_wdata[BIT_WINDOW_MATCH];
    end
    if (completion && link.window_hit) begin
      match_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      match_flag_reg <= 1'b0;
    end else begin
      match_flag_reg <= match_flag_next;
    end
  end

  // Control readback merges the live busy level and both flags
  always_comb begin
    control_view                   = control_reg;
    control_view[BIT_DONE]         = done_flag_reg;
    control_view[BIT_IN_PROGRESS]  = conversion_in_progress;
    control_view[BIT_WINDOW_MATCH] = match_flag_reg;
  end

  // Read data is registered, so it trails the address by one cycle
  always_comb begin
    unique case (sfr_addr)
      ADDR_RESULT_LOW:  rdata_next = result_low_reg;
      ADDR_RESULT_HIGH: rdata_next = result_high_reg;
      ADDR_UPPER_LOW:   rdata_next = upper_limit_reg[7:0];
      ADDR_UPPER_HIGH:  rdata_next = upper_limit_reg[15:8];
      ADDR_LOWER_LOW:   rdata_next = lower_limit_reg[7:0];
      ADDR_LOWER_HIGH:  rdata_next = lower_limit_reg[15:8];
      ADDR_CONTROL:     rdata_next = control_view;
      // Unmapped addresses read as zero
      default:          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata            = rdata_reg;
  assign start_request        = start_reg;
  assign conversion_done_flag = done_flag_reg;
  assign window_match_flag    = match_flag_reg;
endmodule // adc_result_window_detect
`default_nettype wire

// ==== adc_result_chk.sv ====
// Port checker for the converter result and window block
`timescale 1ns/1ps
`default_nettype none
module adc_result_chk
  import adc_result_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        conversion_in_progress,
  input wire logic [11:0] conversion_code,
  input wire logic        differential_input,
  input wire logic        start_request,
  input wire logic        conversion_done_flag,
  input wire logic        window_match_flag
);
  logic busy_reg;
  wire  fall = busy_reg & ~conversion_in_progress;
  wire  cw   = sfr_wr && (sfr_addr == ADDR_CONTROL);
  always_ff @(posedge clk) begin
    busy_reg <= nrst & conversion_in_progress;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence up_write;
    sfr_wr && sfr_addr == ADDR_UPPER_HIGH ##1 !sfr_wr && sfr_addr == ADDR_UPPER_HIGH;
  endsequence
  a_done_on_fall: assert property (fall |=> conversion_done_flag)
    else $error("done flag not set");
  a_done_hold: assert property (conversion_done_flag && !cw |=> conversion_done_flag)
    else $error("done flag lost");
  a_match_hold: assert property (window_match_flag && !cw |=> window_match_flag)
    else $error("match flag lost");
  a_match_cause: assert property (!window_match_flag && !fall && !cw |=> !window_match_flag)
    else $error("match flag without cause");
  a_start_pulse: assert property (cw && sfr_wdata[BIT_IN_PROGRESS] |=> start_request)
    else $error("start pulse missing");
  a_start_idle: assert property (!(cw && sfr_wdata[BIT_IN_PROGRESS]) |=> !start_request)
    else $error("start pulse unexpected");
  a_unmapped_zero: assert property (sfr_addr > ADDR_CONTROL |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_limit_readback: assert property (up_write |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("upper limit readback");
  a_reset_clear: assert property (disable iff (1'b0)
    !nrst |=> sfr_rdata == 8'h00 && !window_match_flag && !start_request)
    else $error("outputs not cleared by reset");
endmodule // adc_result_chk
bind adc_result_window_detect adc_result_chk u_chk (.*);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the converter result and window block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench
  import adc_result_pkg::*;
;
  logic clk, nrst, sfr_wr, busy, diff, start, done, match, wm;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [11:0] code;
  int          tests_run, miscompares;
  adc_result_window_detect DUT (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conversion_in_progress(busy),
    .conversion_code(code), .differential_input(diff), .start_request(start),
    .conversion_done_flag(done), .window_match_flag(match));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask
  function automatic logic hit(input logic [15:0] w, up, lo, input logic df);
    logic gt, lt, inv;
    gt = df ? ($signed(w) > $signed(up)) : (w > up);
    lt = df ? ($signed(w) < $signed(lo)) : (w < lo);
    inv = df ? ($signed(lo) > $signed(up)) : (lo > up);
    return inv ? (gt && lt) : (gt || lt);
  endfunction
  // Load limits, optionally clear flags, convert, then read back result and control
  task automatic run(input logic [11:0] c, input logic df, lj, clr, input logic [15:0] up, lo);
    logic [7:0]  h;
    logic [15:0] w;
    w = lj ? {c, 4'h0} : {{4{df & c[11]}}, c};
    wm = hit(w, up, lo, df) | (wm & ~clr);
    wr(ADDR_UPPER_HIGH, up[15:8]);
    wr(ADDR_UPPER_LOW, up[7:0]);
    wr(ADDR_LOWER_HIGH, lo[15:8]);
    wr(ADDR_LOWER_LOW, lo[7:0]);
    if (clr) wr(ADDR_CONTROL, {7'h00, lj});
    @(posedge clk);
    busy <= 1'b1;
    code <= c;
    diff <= df;
    @(posedge clk);
    busy <= 1'b0;
    rd(ADDR_RESULT_HIGH, h); `CHK(h, w[15:8])
    rd(ADDR_RESULT_LOW, h); `CHK(h, w[7:0])
    rd(ADDR_CONTROL, h); `CHK(h, {2'b00, 1'b1, 3'b000, wm, lj})
    `CHK(match, wm)
    `CHK(done, 1'b1)
  endtask
  task automatic t_regs;
    logic [7:0] a[8] = '{8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8, 8'hF0};
    logic [7:0] e[8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d); `CHK(d, e[i])
    end
    wr(ADDR_UPPER_HIGH, 8'hA5);
    rd(ADDR_UPPER_HIGH, d); `CHK(d, 8'hA5)
    wr(ADDR_LOWER_HIGH, 8'h5A);
    rd(ADDR_LOWER_HIGH, d); `CHK(d, 8'h5A)
  endtask
  task automatic t_format;
    logic [11:0] c[4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h001};
    for (int i = 0; i < 16; i++) begin
      run(c[i%4], i[2], i[3], 1'b1, 16'hFFFF, 16'h0000);
    end
  endtask
  task automatic t_window;
    run(12'h900, 1'b0, 1'b0, 1'b1, 16'h0800, 16'h0100);
    run(12'h400, 1'b0, 1'b0, 1'b1, 16'h0800, 16'h0100);
    run(12'h050, 1'b0, 1'b0, 1'b1, 16'h0800, 16'h0100);
    run(12'h400, 1'b0, 1'b0, 1'b1, 16'h0100, 16'h0800);
    run(12'h900, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0800);
    run(12'hFFF, 1'b1, 1'b1, 1'b1, 16'h0010, 16'hFF00);
    run(12'h800, 1'b1, 1'b1, 1'b1, 16'h0010, 16'hFF00);
  endtask
  task automatic t_start;
    wr(ADDR_CONTROL, 8'h10);
    #1 `CHK(start, 1'b1)
    `CHK(match, 1'b0)
    @(posedge clk);
    #1 `CHK(start, 1'b0)
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {nrst, sfr_wr, busy, diff, wm, sfr_addr, sfr_wdata, code} = '0;
    tests_run = 0;
    miscompares = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_format();
    t_window();
    t_start();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
